// *** ccd_pkg.sv ***
// Constants, types and helpers for the calendar clock
// Overview of operation
// - One second per full 32768 Hz timebase count
// - Second boundary: interrupt, update fields, then tick
// - Tick event stays set until software clears it
// - Clock disabled: no advance, no ping, no tick
// - Separate fields in fixed ranges; 16-bit year
// - Day of week 3 bits; 7 means unknown
// - Host reads and writes 15-bit sub-second fraction
// - Zero command clears fraction only
// - Tied control, client setting: push time each second
// - User change of tied control loads time
// - Hourly check of selected daylight rule; apply shift
// - After shift, swap rule for seasonal counterpart
// - Selector loads build default; host may overwrite
// - Weekday rule: first such day on/after date
// - Rule table: 0 none, 1-26 advance, 33-58 retard
package ccd_pkg;

    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned TIMEBASE_HZ = 32768;
    localparam int          ACC_W       = 25;
    localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TIMEBASE_HZ);

    localparam int          FRAC_W      = 15;
    localparam logic [14:0] FRAC_MAX    = 15'h7fff;
    localparam logic [14:0] FRAC_RST    = 15'h0000;

    localparam logic [5:0]  SEC_LAST    = 6'h3b;
    localparam logic [5:0]  MIN_LAST    = 6'h3b;
    localparam logic [4:0]  HOUR_LAST   = 5'h17;
    localparam logic [3:0]  MONTH_LAST  = 4'hc;
    localparam logic [2:0]  DOW_LAST    = 3'h6;
    localparam logic [2:0]  DOW_UNKNOWN = 3'h7;
    localparam logic [2:0]  DOW_ANY     = 3'h7;

    localparam logic [6:0]  DST_RULE_OFF    = 7'h00;
    localparam logic [6:0]  DST_RULE_DEFAULT = 7'h00;
    localparam logic [6:0]  DST_SEASON_FLIP = 7'h20;

    typedef struct packed {
        logic [15:0] year;
        logic [3:0]  month;
        logic [2:0]  dow;
        logic [4:0]  date;
        logic [4:0]  hour;
        logic [5:0]  min;
        logic [5:0]  sec;
    } ccd_time_t;

    localparam ccd_time_t TIME_RST = '{year: 16'h0000, month: 4'h1, dow: 3'h7,
                                       date: 5'h01, hour: 5'h00, min: 6'h00, sec: 6'h00};

    typedef struct packed {
        logic       valid;
        logic       retard;
        logic [1:0] shift;
        logic [3:0] month;
        logic [4:0] date;
        logic [2:0] dow;
        logic [4:0] hour;
    } ccd_dst_rule_t;

    typedef enum logic [1:0] {ST_IDLE, ST_UPDATE, ST_DST, ST_TICK} ccd_state_t;

    function automatic ccd_dst_rule_t ccd_rule(input logic       retard,
                                               input logic [1:0] shift,
                                               input logic [3:0] month,
                                               input logic [4:0] date,
                                               input logic [2:0] dow,
                                               input logic [4:0] hour);
        ccd_rule = '{valid: 1'b1, retard: retard, shift: shift, month: month,
                     date: date, dow: dow, hour: hour};
    endfunction : ccd_rule

    function automatic logic ccd_leap(input logic [15:0] year);
        ccd_leap = (year % 16'd4 == 16'd0)
                   && ((year % 16'd100 != 16'd0) || (year % 16'd400 == 16'd0));
    endfunction : ccd_leap

    function automatic logic [4:0] ccd_month_days(input logic [3:0]  month,
                                                  input logic [15:0] year);
        unique case (month)
            4'h2:                      ccd_month_days = ccd_leap(year) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hb:    ccd_month_days = 5'd30;
            default:                   ccd_month_days = 5'd31;
        endcase
    endfunction : ccd_month_days

endpackage : ccd_pkg

// *** ccd_tick_gen.sv ***
// Fractional divider: 32768 Hz enable pulses from the system clock
`timescale 1ns/1ns
`default_nettype none
module ccd_tick_gen
    import ccd_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    output logic      tb_en_o
);
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic             en_r;
    logic             en_nxt;

    // Phase accumulator keeps the long-term rate exact
    always_comb begin
        if (acc_r + ACC_STEP >= ACC_MOD) begin
            acc_nxt = acc_r + ACC_STEP - ACC_MOD;
            en_nxt  = 1'b1;
        end else begin
            acc_nxt = acc_r + ACC_STEP;
            en_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_r <= '0;
            en_r  <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            en_r  <= en_nxt;
        end
    end

    assign tb_en_o = en_r;
endmodule : ccd_tick_gen
`default_nettype wire

// *** ccd_dst_rom.sv ***
// Daylight-saving rule table with registered read
`timescale 1ns/1ns
`default_nettype none
module ccd_dst_rom
    import ccd_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic [6:0]    code_i,
    output ccd_dst_rule_t      rule_o
);
    ccd_dst_rule_t e;
    ccd_dst_rule_t rule_r;

    // Fields: retard, shift, month, date, weekday (7 any), hour
    always_comb begin
        unique case (code_i)
            7'd1:  e = ccd_rule(1'b0, 2'd1, 4'd10, 5'd25, 3'd0, 5'd0);
            7'd33: e = ccd_rule(1'b1, 2'd1, 4'd3,  5'd25, 3'd0, 5'd1);
            7'd2:  e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd0, 5'd0);
            7'd34: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd3:  e = ccd_rule(1'b0, 2'd1, 4'd11, 5'd1,  3'd0, 5'd0);
            7'd35: e = ccd_rule(1'b1, 2'd1, 4'd2,  5'd15, 3'd0, 5'd1);
            7'd4:  e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd0, 5'd0);
            7'd36: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd5:  e = ccd_rule(1'b0, 2'd1, 4'd10, 5'd8,  3'd6, 5'd0);
            7'd37: e = ccd_rule(1'b1, 2'd1, 4'd3,  5'd8,  3'd6, 5'd1);
            7'd6:  e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd7, 5'd0);
            7'd38: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd7:  e = ccd_rule(1'b0, 2'd1, 4'd3,  5'd25, 3'd0, 5'd0);
            7'd39: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd8:  e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd24, 3'd5, 5'd0);
            7'd40: e = ccd_rule(1'b1, 2'd1, 4'd9,  5'd24, 3'd4, 5'd1);
            7'd9:  e = ccd_rule(1'b0, 2'd1, 4'd9,  5'd8,  3'd0, 5'd0);
            7'd41: e = ccd_rule(1'b1, 2'd1, 4'd4,  5'd6,  3'd0, 5'd1);
            7'd10: e = ccd_rule(1'b0, 2'd1, 4'd3,  5'd25, 3'd0, 5'd1);
            7'd42: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd2);
            7'd11: e = ccd_rule(1'b0, 2'd1, 4'd1,  5'd1,  3'd7, 5'd0);
            7'd43: e = ccd_rule(1'b1, 2'd1, 4'd7,  5'd1,  3'd7, 5'd1);
            7'd12: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd7, 5'd0);
            7'd44: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd1,  3'd7, 5'd1);
            7'd13: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd5, 5'd0);
            7'd45: e = ccd_rule(1'b1, 2'd1, 4'd9,  5'd1,  3'd5, 5'd1);
            7'd14: e = ccd_rule(1'b0, 2'd1, 4'd3,  5'd25, 3'd0, 5'd0);
            7'd46: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd15: e = ccd_rule(1'b0, 2'd1, 4'd3,  5'd25, 3'd0, 5'd0);
            7'd47: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd16: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd0, 5'd0);
            7'd48: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd17: e = ccd_rule(1'b0, 2'd1, 4'd9,  5'd1,  3'd0, 5'd0);
            7'd49: e = ccd_rule(1'b1, 2'd1, 4'd4,  5'd1,  3'd0, 5'd1);
            7'd18: e = ccd_rule(1'b0, 2'd1, 4'd10, 5'd1,  3'd0, 5'd0);
            7'd50: e = ccd_rule(1'b1, 2'd1, 4'd3,  5'd15, 3'd0, 5'd1);
            7'd19: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd15, 3'd5, 5'd0);
            7'd51: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd15, 3'd5, 5'd1);
            7'd20: e = ccd_rule(1'b0, 2'd1, 4'd9,  5'd1,  3'd0, 5'd0);
            7'd52: e = ccd_rule(1'b1, 2'd1, 4'd4,  5'd1,  3'd0, 5'd1);
            7'd21: e = ccd_rule(1'b0, 2'd2, 4'd3,  5'd25, 3'd0, 5'd2);
            7'd53: e = ccd_rule(1'b1, 2'd2, 4'd10, 5'd25, 3'd0, 5'd4);
            7'd22: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd7, 5'd0);
            7'd54: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd1,  3'd7, 5'd1);
            7'd23: e = ccd_rule(1'b0, 2'd1, 4'd10, 5'd1,  3'd0, 5'd0);
            7'd55: e = ccd_rule(1'b1, 2'd1, 4'd3,  5'd1,  3'd0, 5'd1);
            7'd24: e = ccd_rule(1'b0, 2'd1, 4'd11, 5'd1,  3'd0, 5'd0);
            7'd56: e = ccd_rule(1'b1, 2'd1, 4'd1,  5'd25, 3'd0, 5'd1);
            7'd25: e = ccd_rule(1'b0, 2'd1, 4'd4,  5'd1,  3'd0, 5'd0);
            7'd57: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd1);
            7'd26: e = ccd_rule(1'b0, 2'd1, 4'd3,  5'd25, 3'd0, 5'd1);
            7'd58: e = ccd_rule(1'b1, 2'd1, 4'd10, 5'd25, 3'd0, 5'd2);
            default: e = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        rule_r <= e;
    end

    assign rule_o = rule_r;
endmodule : ccd_dst_rom
`default_nettype wire

// *** ccd_rtc.sv ***
// Calendar clock core: fraction counter, rollover, daylight rule, tick
`timescale 1ns/1ns
`default_nettype none
module ccd_rtc
    import ccd_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        clock_enable_setting_i,
    input  wire logic        client_update_setting_i,
    input  wire logic        suspend_clock_irq_i,
    input  wire logic        time_wr_i,
    input  wire ccd_time_t   time_wdata_i,
    input  wire logic        write_subsecond_i,
    input  wire logic [14:0] subsecond_wdata_i,
    input  wire logic        zero_subsecond_i,
    input  wire logic        ui_tied_i,
    input  wire logic        ui_load_i,
    input  wire ccd_time_t   ui_time_i,
    input  wire logic        dst_wr_i,
    input  wire logic [6:0]  dst_wdata_i,
    input  wire logic        tick_clear_i,
    output ccd_time_t        current_time_fields_o,
    output logic [14:0]      read_subsecond_o,
    output logic [6:0]       dst_rule_selector_o,
    output logic             sec_irq_o,
    output logic             second_tick_event_o,
    output logic             client_push_o,
    output ccd_time_t        client_time_o
);
    logic          tb_en;
    ccd_dst_rule_t rule;
    ccd_state_t  state_r;
    ccd_state_t  state_nxt;
    ccd_time_t   time_r;
    ccd_time_t   time_nxt;
    logic [14:0] frac_r;
    logic [14:0] frac_nxt;
    logic [6:0]  dst_r;
    logic [6:0]  dst_nxt;
    logic        pend_r;
    logic        pend_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        tick_r;
    logic        tick_nxt;
    logic        push_r;
    logic        push_nxt;
    ccd_time_t   ctime_r;
    ccd_time_t   ctime_nxt;

    logic        wrap;
    logic        start;
    logic        dow_ok;
    logic        dst_hit;
    logic [4:0]  mdays;
    logic [4:0]  date_end;

    ccd_tick_gen u_tick_gen (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tb_en_o   (tb_en)
    );

    ccd_dst_rom u_dst_rom (
        .clk_sys_i (clk_sys_i),
        .code_i    (dst_r),
        .rule_o    (rule)
    );

    // First matching weekday on or after rule date
    always_comb begin
        date_end = rule.date + 5'd6;
        if (rule.dow == DOW_ANY) begin
            dow_ok = (time_r.date == rule.date);
        end else begin
            dow_ok = (time_r.dow == rule.dow) && (time_r.date >= rule.date)
                     && (time_r.date <= date_end);
        end
        dst_hit = rule.valid && (time_r.min == 6'h00) && (time_r.sec == 6'h00)
                  && (time_r.hour == rule.hour) && (time_r.month == rule.month)
                  && dow_ok;
        mdays = ccd_month_days(time_r.month, time_r.year);
    end

    always_comb begin
        state_nxt = state_r;
        time_nxt  = time_r;
        frac_nxt  = frac_r;
        dst_nxt   = dst_r;
        pend_nxt  = pend_r;
        irq_nxt   = 1'b0;
        tick_nxt  = tick_r;
        push_nxt  = 1'b0;
        ctime_nxt = ctime_r;

        // Wrap past maximum marks the second boundary
        wrap = clock_enable_setting_i && tb_en && (frac_r == FRAC_MAX);
        if (clock_enable_setting_i && tb_en) begin
            frac_nxt = frac_r + 15'd1;
        end
        if (write_subsecond_i) begin
            frac_nxt = subsecond_wdata_i;
        end else if (zero_subsecond_i) begin
            frac_nxt = FRAC_RST;
        end

        // Boundaries wait out a host suspend
        if (wrap) begin
            pend_nxt = 1'b1;
        end
        start = (wrap || pend_r) && !suspend_clock_irq_i && (state_r == ST_IDLE);
        if (!clock_enable_setting_i) begin
            pend_nxt = 1'b0;
            start    = 1'b0;
        end

        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    pend_nxt  = 1'b0;
                    irq_nxt   = 1'b1;
                    state_nxt = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                // Carry chain from seconds up to year
                if (time_r.sec != SEC_LAST) begin
                    time_nxt.sec = time_r.sec + 6'd1;
                end else begin
                    time_nxt.sec = 6'h00;
                    if (time_r.min != MIN_LAST) begin
                        time_nxt.min = time_r.min + 6'd1;
                    end else begin
                        time_nxt.min = 6'h00;
                        if (time_r.hour != HOUR_LAST) begin
                            time_nxt.hour = time_r.hour + 5'd1;
                        end else begin
                            time_nxt.hour = 5'h00;
                            if (time_r.dow == DOW_UNKNOWN) begin
                                time_nxt.dow = DOW_UNKNOWN;
                            end else if (time_r.dow == DOW_LAST) begin
                                time_nxt.dow = 3'h0;
                            end else begin
                                time_nxt.dow = time_r.dow + 3'd1;
                            end
                            if (time_r.date < mdays) begin
                                time_nxt.date = time_r.date + 5'd1;
                            end else begin
                                time_nxt.date = 5'h01;
                                if (time_r.month < MONTH_LAST) begin
                                    time_nxt.month = time_r.month + 4'd1;
                                end else begin
                                    time_nxt.month = 4'h1;
                                    time_nxt.year  = time_r.year + 16'd1;
                                end
                            end
                        end
                    end
                end
                state_nxt = ST_DST;
            end
            ST_DST: begin
                if (dst_hit) begin
                    if (rule.retard) begin
                        time_nxt.hour = time_r.hour - {3'h0, rule.shift};
                    end else begin
                        time_nxt.hour = time_r.hour + {3'h0, rule.shift};
                    end
                    dst_nxt = dst_r ^ DST_SEASON_FLIP;
                end
                state_nxt = ST_TICK;
            end
            ST_TICK: begin
                tick_nxt = 1'b1;
                if (ui_tied_i && client_update_setting_i) begin
                    push_nxt  = 1'b1;
                    ctime_nxt = time_r;
                end
                state_nxt = ST_IDLE;
            end
        endcase

        // Writes override the carry update
        if (time_wr_i) begin
            time_nxt = time_wdata_i;
        end else if (ui_tied_i && ui_load_i) begin
            time_nxt = ui_time_i;
        end
        if (dst_wr_i) begin
            dst_nxt = dst_wdata_i;
        end

        // Set wins over a same-cycle clear
        if (tick_clear_i && (state_r != ST_TICK)) begin
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            time_r  <= TIME_RST;
            frac_r  <= FRAC_RST;
            dst_r   <= DST_RULE_DEFAULT;
            pend_r  <= 1'b0;
            irq_r   <= 1'b0;
            tick_r  <= 1'b0;
            push_r  <= 1'b0;
            ctime_r <= TIME_RST;
        end else begin
            state_r <= state_nxt;
            time_r  <= time_nxt;
            frac_r  <= frac_nxt;
            dst_r   <= dst_nxt;
            pend_r  <= pend_nxt;
            irq_r   <= irq_nxt;
            tick_r  <= tick_nxt;
            push_r  <= push_nxt;
            ctime_r <= ctime_nxt;
        end
    end

    assign current_time_fields_o = time_r;
    assign read_subsecond_o      = frac_r;
    assign dst_rule_selector_o   = dst_r;
    assign sec_irq_o             = irq_r;
    assign second_tick_event_o   = tick_r;
    assign client_push_o         = push_r;
    assign client_time_o         = ctime_r;
endmodule : ccd_rtc
`default_nettype wire

// *** ccd_rtc_props.sv ***
// Concurrent checks on the clock core ports
`timescale 1ns/1ns
`default_nettype none
module ccd_rtc_props
    import ccd_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        clock_enable_setting_i,
    input wire logic        client_update_setting_i,
    input wire logic        ui_tied_i,
    input wire logic        write_subsecond_i,
    input wire logic [14:0] subsecond_wdata_i,
    input wire logic        zero_subsecond_i,
    input wire logic        dst_wr_i,
    input wire logic [6:0]  dst_wdata_i,
    input wire logic        tick_clear_i,
    input wire ccd_time_t   current_time_fields_o,
    input wire logic [14:0] read_subsecond_o,
    input wire logic [6:0]  dst_rule_selector_o,
    input wire logic        sec_irq_o,
    input wire logic        second_tick_event_o,
    input wire logic        client_push_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Boundary walk: irq, update, daylight step, tick
    sequence s_tick_after;
        ##3 second_tick_event_o;
    endsequence
    sequence s_quiet;
        !clock_enable_setting_i [*5];
    endsequence
    irq_to_tick_a: assert property (sec_irq_o |-> s_tick_after)
        else $error("tick late after irq");
    irq_pulse_a: assert property (sec_irq_o |=> !sec_irq_o [*3])
        else $error("irq longer than one cycle");
    tick_cause_a: assert property ($rose(second_tick_event_o) |-> $past(sec_irq_o, 3))
        else $error("tick without irq");
    tick_hold_a: assert property (second_tick_event_o && !tick_clear_i |=> second_tick_event_o)
        else $error("tick dropped uncleared");
    tick_clear_a: assert property (second_tick_event_o && tick_clear_i
        && !$past(sec_irq_o, 2) |=> !second_tick_event_o)
        else $error("tick not cleared");
    disabled_quiet_a: assert property (s_quiet |-> !sec_irq_o && !client_push_o
        && !$rose(second_tick_event_o))
        else $error("activity while disabled");
    frac_frozen_a: assert property (!clock_enable_setting_i && !write_subsecond_i
        && !zero_subsecond_i |=> $stable(read_subsecond_o))
        else $error("fraction moved while disabled");
    frac_write_a: assert property (write_subsecond_i
        |=> read_subsecond_o == $past(subsecond_wdata_i))
        else $error("fraction write lost");
    frac_zero_a: assert property (zero_subsecond_i && !write_subsecond_i
        |=> read_subsecond_o == 15'h0000)
        else $error("fraction not zeroed");
    dst_write_a: assert property (dst_wr_i && !$past(sec_irq_o)
        |=> dst_rule_selector_o == $past(dst_wdata_i))
        else $error("selector write lost");
    push_gate_a: assert property (client_push_o |-> ui_tied_i && client_update_setting_i
        && $past(sec_irq_o, 3))
        else $error("unexpected client push");
    fields_range_a: assert property (current_time_fields_o.sec <= SEC_LAST
        && current_time_fields_o.min <= MIN_LAST && current_time_fields_o.hour <= HOUR_LAST
        && current_time_fields_o.month <= MONTH_LAST && current_time_fields_o.date != 5'h00)
        else $error("time field out of range");
endmodule : ccd_rtc_props

bind ccd_rtc ccd_rtc_props ccd_rtc_props_inst (.clk_sys_i, .rst_i, .clock_enable_setting_i,
    .client_update_setting_i, .ui_tied_i, .write_subsecond_i, .subsecond_wdata_i,
    .zero_subsecond_i, .dst_wr_i, .dst_wdata_i, .tick_clear_i, .current_time_fields_o,
    .read_subsecond_o, .dst_rule_selector_o, .sec_irq_o, .second_tick_event_o, .client_push_o);
`default_nettype wire

// *** ccd_host_model.sv ***
// Host stand-in: guarded time writes and tick clearing
`timescale 1ns/1ns
`default_nettype none
module ccd_host_model
    import ccd_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic auto_clear_i,
    input  wire logic second_tick_event_i,
    output logic      suspend_clock_irq_o,
    output logic      time_wr_o,
    output ccd_time_t time_wdata_o,
    output logic      tick_clear_o
);
    initial begin
        suspend_clock_irq_o = 1'b0;
        time_wr_o = 1'b0;
        time_wdata_o = TIME_RST;
        tick_clear_o = 1'b0;
    end
    task automatic set_time(input ccd_time_t t);
        @(posedge clk_sys_i);
        #1;
        suspend_clock_irq_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        time_wr_o = 1'b1;
        time_wdata_o = t;
        @(posedge clk_sys_i);
        #1;
        time_wr_o = 1'b0;
        suspend_clock_irq_o = 1'b0;
    endtask : set_time
    always @(posedge clk_sys_i) begin
        #1;
        tick_clear_o = auto_clear_i && second_tick_event_i && !tick_clear_o;
    end
endmodule : ccd_host_model
`default_nettype wire

// *** test_calendar_clock_dst.sv ***
// Self-checking bench for the calendar clock core
`timescale 1ns/1ns
`default_nettype none
module test_calendar_clock_dst
    import ccd_pkg::*;
();
    logic        clk_sys_i, rst_i, clock_enable_setting_i, client_update_setting_i, ui_tied_i;
    logic        write_subsecond_i, zero_subsecond_i, ui_load_i, dst_wr_i, auto_clear;
    logic        suspend_clock_irq_i, time_wr_i, tick_clear_i;
    logic        sec_irq_o, second_tick_event_o, client_push_o;
    logic [14:0] subsecond_wdata_i, read_subsecond_o;
    logic [6:0]  dst_wdata_i, dst_rule_selector_o;
    ccd_time_t   time_wdata_i, ui_time_i, current_time_fields_o, client_time_o;
    int          miscompares = 0;
    int          tests_run = 0;
    ccd_rtc ccd_rtc_inst (.clk_sys_i, .rst_i, .clock_enable_setting_i, .client_update_setting_i,
        .suspend_clock_irq_i, .time_wr_i, .time_wdata_i, .write_subsecond_i, .subsecond_wdata_i,
        .zero_subsecond_i, .ui_tied_i, .ui_load_i, .ui_time_i, .dst_wr_i, .dst_wdata_i,
        .tick_clear_i, .current_time_fields_o, .read_subsecond_o, .dst_rule_selector_o,
        .sec_irq_o, .second_tick_event_o, .client_push_o, .client_time_o);
    ccd_host_model ccd_host_model_inst (.clk_sys_i, .auto_clear_i(auto_clear),
        .second_tick_event_i(second_tick_event_o), .suspend_clock_irq_o(suspend_clock_irq_i),
        .time_wr_o(time_wr_i), .time_wdata_o(time_wdata_i), .tick_clear_o(tick_clear_i));
    task automatic check(input logic [44:0] seen, input logic [44:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    function automatic ccd_time_t mk(input int y, mo, dw, d, h, mi, s);
        mk = '{16'(y), 4'(mo), 3'(dw), 5'(d), 5'(h), 6'(mi), 6'(s)};
    endfunction : mk
    task automatic wr_frac(input logic [14:0] v);
        write_subsecond_i = 1'b1;
        subsecond_wdata_i = v;
        step(1);
        write_subsecond_i = 1'b0;
    endtask : wr_frac
    task automatic wr_dst(input logic [6:0] c);
        dst_wr_i = 1'b1;
        dst_wdata_i = c;
        step(1);
        dst_wr_i = 1'b0;
    endtask : wr_dst
    task automatic wait_irq();
        for (int i = 0; i < 2000; i++) begin
            step(1);
            if (sec_irq_o === 1'b1) return;
        end
        miscompares++;
        $display("[FAIL] %0t no second boundary", $time);
        test_done();
    endtask : wait_irq
    // One boundary from a set time and rule code
    task automatic roll(input ccd_time_t ti, te, input int code, sel);
        ccd_host_model_inst.set_time(ti);
        wr_dst(7'(code));
        wr_frac(FRAC_MAX);
        wait_irq();
        check(read_subsecond_o, FRAC_RST);
        step(3);
        check(current_time_fields_o, te);
        check(dst_rule_selector_o, 7'(sel));
        check(second_tick_event_o, 1'b1);
        check(client_push_o, ui_tied_i & client_update_setting_i);
        if (client_push_o === 1'b1) check(client_time_o, te);
    endtask : roll
    task automatic t_disabled();
        int n = 0;
        clock_enable_setting_i = 1'b0;
        wr_frac(FRAC_MAX);
        for (int i = 0; i < 1600; i++) begin
            step(1);
            if (sec_irq_o === 1'b1) n++;
        end
        check(n, 0);
        check(read_subsecond_o, FRAC_MAX);
        zero_subsecond_i = 1'b1;
        step(1);
        zero_subsecond_i = 1'b0;
        check(read_subsecond_o, FRAC_RST);
        check(current_time_fields_o, TIME_RST);
        clock_enable_setting_i = 1'b1;
        $display("test disabled done");
    endtask : t_disabled
    task automatic t_rolls();
        roll(mk(2023, 12, 6, 31, 23, 59, 59), mk(2024, 1, 0, 1, 0, 0, 0), 0, 0);
        roll(mk(2024, 2, 3, 28, 23, 59, 59), mk(2024, 2, 4, 29, 0, 0, 0), 0, 0);
        roll(mk(2100, 2, 1, 28, 23, 59, 59), mk(2100, 3, 2, 1, 0, 0, 0), 0, 0);
        roll(mk(2000, 2, 1, 28, 23, 59, 59), mk(2000, 2, 2, 29, 0, 0, 0), 0, 0);
        roll(mk(2024, 4, 2, 30, 23, 59, 59), mk(2024, 5, 3, 1, 0, 0, 0), 0, 0);
        ui_tied_i = 1'b1;
        client_update_setting_i = 1'b1;
        roll(mk(2024, 3, 0, 31, 1, 59, 59), mk(2024, 3, 0, 31, 4, 0, 0), 21, 53);
        roll(mk(2024, 10, 0, 27, 3, 59, 59), mk(2024, 10, 0, 27, 2, 0, 0), 53, 21);
        roll(mk(2024, 3, 0, 31, 23, 59, 59), mk(2024, 4, 1, 1, 1, 0, 0), 6, 38);
        roll(mk(2024, 3, 0, 24, 1, 59, 59), mk(2024, 3, 0, 24, 2, 0, 0), 21, 21);
        roll(mk(2024, 3, 0, 31, 0, 59, 59), mk(2024, 3, 0, 31, 2, 0, 0), 26, 58);
        roll(mk(2024, 10, 0, 27, 1, 59, 59), mk(2024, 10, 0, 27, 1, 0, 0), 58, 26);
        roll(mk(2024, 3, 0, 31, 1, 59, 59), mk(2024, 3, 0, 31, 2, 0, 0), 0, 0);
        $display("test rolls done");
    endtask : t_rolls
    task automatic t_misc();
        for (int c = 0; c <= 58; c++) begin
            wr_dst(7'(c));
            check(dst_rule_selector_o, 7'(c));
            step(1);
        end
        auto_clear = 1'b0;
        client_update_setting_i = 1'b0;
        roll(mk(2024, 6, 0, 30, 23, 59, 59), mk(2024, 7, 1, 1, 0, 0, 0), 0, 0);
        step(20);
        check(second_tick_event_o, 1'b1);
        auto_clear = 1'b1;
        step(3);
        check(second_tick_event_o, 1'b0);
        ui_time_i = mk(2030, 5, 3, 15, 12, 34, 56);
        ui_load_i = 1'b1;
        step(1);
        check(current_time_fields_o, ui_time_i);
        ui_tied_i = 1'b0;
        ui_time_i = ~ui_time_i;
        step(1);
        ui_load_i = 1'b0;
        check(current_time_fields_o, ~ui_time_i);
        $display("test misc done");
    endtask : t_misc
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        {rst_i, clock_enable_setting_i, auto_clear, ui_load_i, dst_wr_i} = 5'h1c;
        {client_update_setting_i, ui_tied_i, write_subsecond_i, zero_subsecond_i} = 4'h0;
        subsecond_wdata_i = 15'h0000;
        dst_wdata_i = 7'h00;
        ui_time_i = TIME_RST;
        step(20);
        rst_i = 1'b0;
        check(current_time_fields_o, TIME_RST);
        check(current_time_fields_o.dow, DOW_UNKNOWN);
        check(dst_rule_selector_o, DST_RULE_DEFAULT);
        check(second_tick_event_o, 1'b0);
        $display("test reset done");
        t_disabled();
        t_rolls();
        t_misc();
        test_done();
    end
endmodule : test_calendar_clock_dst
`default_nettype wire
